// >>> core_pkg.sv
package core_pkg;
    // widths of the core's datapaths and the return stack depth
    localparam int DATA_W = 8;
    localparam int PC_W = 21;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;
    localparam int FLAGS_W = 5;
    localparam int STACK_DEPTH = 31;

    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    // access bank: offsets at or above the split map to the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

    // reset values and the pc step
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [7:0] PROD_RST = 8'h00;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] LATCH_HIGH_RST = 8'h00;
    localparam logic [4:0] LATCH_UPPER_RST = 5'h00;
    localparam logic [15:0] IR_RST = 16'h0000;

    // opcode patterns
    localparam logic [15:0] OPC_NOP = 16'h0000;
    localparam logic [3:0] OPC_NOP_TOP = 4'hf;
    localparam logic [7:0] OPC_MUL_LIT = 8'h0d;
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;
    localparam logic [6:0] OPC_NEGATE = 7'h36;
    localparam logic [15:0] OPC_POP = 16'h0006;
    localparam logic [15:0] OPC_PUSH = 16'h0005;
    localparam logic [4:0] OPC_REL_CALL = 5'h1b;
    localparam logic [15:0] OPC_SWRESET = 16'h00ff;
    localparam logic [14:0] OPC_IRET = 15'h0008;
    localparam logic [7:0] OPC_RET_LIT = 8'h0c;

    // instruction cycle phases, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_MUL_LIT,
        OP_MUL_FILE,
        OP_NEGATE,
        OP_POP,
        OP_PUSH,
        OP_REL_CALL,
        OP_SWRESET,
        OP_IRET,
        OP_RET_LIT,
        OP_OTHER
    } op_t;
endpackage

// >>> mul_neg_stack_return_ops.sv
`timescale 1ns/1ps
module mul_neg_stack_return_ops
    import core_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // program memory
    input wire logic [15:0] instr_word,
    output logic [PC_W-1:0] prog_addr,
    // register file
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [ADDR_W-1:0] file_addr,
    output logic [DATA_W-1:0] file_wdata,
    output logic file_we,
    // shadow copies, loaded by interrupt entry elsewhere
    input wire logic [DATA_W-1:0] accumulator_shadow,
    input wire logic [FLAGS_W-1:0] flags_shadow,
    input wire logic [BANK_W-1:0] bank_select_shadow,
    // pc latch load from elsewhere in the core
    input wire logic pclat_load,
    input wire logic [7:0] pclat_high_value,
    input wire logic [4:0] pclat_upper_value,
    // architectural state
    output logic [DATA_W-1:0] accumulator,
    output logic [FLAGS_W-1:0] status_flags,
    output logic [BANK_W-1:0] bank_select_register,
    output logic [DATA_W-1:0] product_high_byte,
    output logic [DATA_W-1:0] product_low_byte,
    output logic [PC_W-1:0] return_stack_top,
    output logic high_priority_global_enable,
    output logic low_priority_global_enable,
    output logic [7:0] pc_latch_high,
    output logic [4:0] pc_latch_upper,
    output logic flush_cycle
);
    phase_t phase, next_phase;
    logic [15:0] ir, next_ir;
    logic [PC_W-1:0] next_pc;
    logic [ADDR_W-1:0] next_file_addr;
    logic [DATA_W-1:0] next_file_wdata;
    logic next_file_we;
    logic [DATA_W-1:0] next_acc;
    logic [FLAGS_W-1:0] next_flags;
    logic [BANK_W-1:0] next_bank;
    logic [DATA_W-1:0] next_prod_hi, next_prod_lo;
    logic next_hi_en, next_lo_en, next_flush;
    logic [7:0] next_lat_high;
    logic [4:0] next_lat_upper;
    logic stk_push, stk_pop, stk_clear;
    logic [PC_W-1:0] stk_value;
    logic [15:0] product;
    logic [DATA_W-1:0] negated;
    logic [PC_W-1:0] call_offset;
    logic exec;
    op_t op;

    function automatic op_t decode(input logic [15:0] w);
        op_t o;
        o = OP_OTHER;
        if (w == OPC_NOP || w[15:12] == OPC_NOP_TOP) o = OP_NOP;
        else if (w[15:8] == OPC_MUL_LIT) o = OP_MUL_LIT;
        else if (w[15:9] == OPC_MUL_FILE) o = OP_MUL_FILE;
        else if (w[15:9] == OPC_NEGATE) o = OP_NEGATE;
        else if (w == OPC_POP) o = OP_POP;
        else if (w == OPC_PUSH) o = OP_PUSH;
        else if (w[15:11] == OPC_REL_CALL) o = OP_REL_CALL;
        else if (w == OPC_SWRESET) o = OP_SWRESET;
        else if (w[15:1] == OPC_IRET) o = OP_IRET;
        else if (w[15:8] == OPC_RET_LIT) o = OP_RET_LIT;
        return o;
    endfunction

    // data address for a file operand; used by datapath and checks
    function automatic logic [ADDR_W-1:0] bank_addr(
        input logic a, input logic [7:0] f, input logic [BANK_W-1:0] b);
        logic [BANK_W-1:0] bank;
        bank = b;
        if (!a) begin
            bank = (f >= ACCESS_SPLIT) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK;
        end
        return {bank, f};
    endfunction

    assign op = decode(ir);
    // a flushed cycle executes nothing, whatever was fetched
    assign exec = (phase == PH_Q4) && !flush_cycle;
    assign product = 16'(accumulator) * 16'(ir[15:9] == OPC_MUL_FILE ?
                     file_rdata : ir[7:0]);
    assign negated = DATA_W'(~file_rdata + 8'h01);
    assign call_offset = {{(PC_W-12){ir[10]}}, ir[10:0], 1'b0};

    return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_W)
    ) u_stack (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clear(stk_clear),
        .push(stk_push),
        .pop(stk_pop),
        .push_value(stk_value),
        .top(return_stack_top)
    );

    // next values of the whole core; ir loads in Q1, file_addr in Q2, instruction results commit on the Q4 edge
    always_comb begin
        next_phase = phase;
        case (phase)
            PH_Q1: next_phase = PH_Q2;
            PH_Q2: next_phase = PH_Q3;
            PH_Q3: next_phase = PH_Q4;
            PH_Q4: next_phase = PH_Q1;
            default: next_phase = PH_Q1;
        endcase
        next_ir = (phase == PH_Q1) ? instr_word : ir;
        next_file_addr = file_addr;
        if (phase == PH_Q2) begin
            next_file_addr = bank_addr(ir[8], ir[7:0],
                                       bank_select_register);
        end
        next_pc = prog_addr;
        next_file_wdata = file_wdata;
        next_file_we = 1'b0;
        next_acc = accumulator;
        next_flags = status_flags;
        next_bank = bank_select_register;
        next_prod_hi = product_high_byte;
        next_prod_lo = product_low_byte;
        next_hi_en = high_priority_global_enable;
        next_lo_en = low_priority_global_enable;
        next_flush = flush_cycle;
        next_lat_high = pclat_load ? pclat_high_value : pc_latch_high;
        next_lat_upper = pclat_load ? pclat_upper_value : pc_latch_upper;
        stk_push = 1'b0;
        stk_pop = 1'b0;
        stk_clear = 1'b0;
        stk_value = prog_addr + PC_STEP;
        if (phase == PH_Q4) begin
            // the flush cycle keeps the target pc already loaded
            next_flush = 1'b0;
            if (!flush_cycle) begin
                next_pc = prog_addr + PC_STEP;
            end
        end
        if (exec) begin
            case (op)
                OP_MUL_LIT, OP_MUL_FILE: begin
                    // flags and accumulator deliberately untouched
                    next_prod_hi = product[15:8];
                    next_prod_lo = product[7:0];
                end
                OP_NEGATE: begin
                    next_file_wdata = negated;
                    next_file_we = 1'b1;
                    next_flags[FLAG_N] = negated[7];
                    next_flags[FLAG_OV] = file_rdata == 8'h80;
                    next_flags[FLAG_C] = file_rdata == 8'h00;
                    next_flags[FLAG_DC] = file_rdata[3:0] == 4'h0;
                    next_flags[FLAG_Z] = negated == 8'h00;
                end
                OP_POP: stk_pop = 1'b1;
                OP_PUSH: stk_push = 1'b1;
                OP_REL_CALL: begin
                    stk_push = 1'b1;
                    next_pc = prog_addr + PC_STEP + call_offset;
                    next_flush = 1'b1;
                end
                OP_SWRESET: begin
                    next_pc = PC_RST;
                    next_acc = ACC_RST;
                    next_flags = FLAGS_RST;
                    next_bank = BANK_RST;
                    next_prod_hi = PROD_RST;
                    next_prod_lo = PROD_RST;
                    next_hi_en = 1'b0;
                    next_lo_en = 1'b0;
                    next_lat_high = LATCH_HIGH_RST;
                    next_lat_upper = LATCH_UPPER_RST;
                    stk_clear = 1'b1;
                end
                OP_IRET: begin
                    // pc latches are not written here
                    next_pc = return_stack_top;
                    stk_pop = 1'b1;
                    next_flush = 1'b1;
                    if (!high_priority_global_enable) next_hi_en = 1'b1;
                    else next_lo_en = 1'b1;
                    if (ir[0]) begin
                        next_acc = accumulator_shadow;
                        next_flags = flags_shadow;
                        next_bank = bank_select_shadow;
                    end
                end
                OP_RET_LIT: begin
                    next_acc = ir[7:0];
                    next_pc = return_stack_top;
                    stk_pop = 1'b1;
                    next_flush = 1'b1;
                end
                default: ; // nop and instructions handled elsewhere
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PH_Q1;
            ir <= IR_RST;
            prog_addr <= PC_RST;
            file_addr <= '0;
            file_wdata <= '0;
            file_we <= 1'b0;
            accumulator <= ACC_RST;
            status_flags <= FLAGS_RST;
            bank_select_register <= BANK_RST;
            product_high_byte <= PROD_RST;
            product_low_byte <= PROD_RST;
            high_priority_global_enable <= 1'b0;
            low_priority_global_enable <= 1'b0;
            flush_cycle <= 1'b0;
            pc_latch_high <= LATCH_HIGH_RST;
            pc_latch_upper <= LATCH_UPPER_RST;
        end else begin
            phase <= next_phase;
            ir <= next_ir;
            prog_addr <= next_pc;
            file_addr <= next_file_addr;
            file_wdata <= next_file_wdata;
            file_we <= next_file_we;
            accumulator <= next_acc;
            status_flags <= next_flags;
            bank_select_register <= next_bank;
            product_high_byte <= next_prod_hi;
            product_low_byte <= next_prod_lo;
            high_priority_global_enable <= next_hi_en;
            low_priority_global_enable <= next_lo_en;
            flush_cycle <= next_flush;
            pc_latch_high <= next_lat_high;
            pc_latch_upper <= next_lat_upper;
        end
    end

    // checks, all in the single clock domain
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_exec(op_t o);
        exec && op == o;
    endsequence

    mul_file_product_a: assert property (s_exec(OP_MUL_FILE) |=>
        {product_high_byte, product_low_byte} ==
        16'($past(accumulator)) * 16'($past(file_rdata)))
        else $error("file multiply product wrong");
    mul_file_keeps_a: assert property (s_exec(OP_MUL_FILE) |=>
        accumulator == $past(accumulator) && !file_we &&
        status_flags == $past(status_flags))
        else $error("file multiply changed state");
    mul_lit_product_a: assert property (s_exec(OP_MUL_LIT) |=>
        {product_high_byte, product_low_byte} ==
        16'($past(accumulator)) * 16'($past(ir[7:0])))
        else $error("literal multiply product wrong");
    access_bank_a: assert property (phase == PH_Q3 && !ir[8] |->
        file_addr == bank_addr(1'b0, ir[7:0], bank_select_register))
        else $error("access bank address wrong");
    negate_write_a: assert property (s_exec(OP_NEGATE) |=>
        file_we && file_wdata == 8'h00 - $past(file_rdata) &&
        status_flags[FLAG_Z] == (file_wdata == 8'h00))
        else $error("negate result wrong");
    pop_single_a: assert property (s_exec(OP_POP) |=>
        prog_addr == $past(prog_addr) + PC_STEP && !flush_cycle)
        else $error("pop changed flow");
    push_top_a: assert property (s_exec(OP_PUSH) |=>
        return_stack_top == $past(prog_addr) + PC_STEP)
        else $error("push stored wrong address");
    call_target_a: assert property (s_exec(OP_REL_CALL) |=>
        return_stack_top == $past(prog_addr) + PC_STEP &&
        prog_addr == $past(prog_addr) + PC_STEP + $past(call_offset))
        else $error("relative call target wrong");
    call_flush_a: assert property (s_exec(OP_REL_CALL) |=>
        flush_cycle[*4] ##1 !flush_cycle)
        else $error("relative call flush length wrong");
    swreset_a: assert property (s_exec(OP_SWRESET) |=>
        prog_addr == PC_RST && accumulator == ACC_RST &&
        status_flags == FLAGS_RST && !high_priority_global_enable)
        else $error("software reset incomplete");
    iret_enable_a: assert property (s_exec(OP_IRET) |=>
        prog_addr == $past(return_stack_top) &&
        high_priority_global_enable &&
        (low_priority_global_enable || !$past(high_priority_global_enable)))
        else $error("interrupt return wrong");
    iret_shadow_a: assert property (s_exec(OP_IRET) && !ir[0] |=>
        accumulator == $past(accumulator) &&
        bank_select_register == $past(bank_select_register))
        else $error("shadow restore without bit");
    ret_latch_a: assert property (exec && (op == OP_IRET ||
        op == OP_RET_LIT) && !pclat_load |=>
        pc_latch_high == $past(pc_latch_high) &&
        pc_latch_upper == $past(pc_latch_upper))
        else $error("return touched pc latches");
    ret_lit_a: assert property (s_exec(OP_RET_LIT) |=>
        accumulator == $past(ir[7:0]) && flush_cycle)
        else $error("return with literal wrong");
    nop_a: assert property (s_exec(OP_NOP) |=>
        accumulator == $past(accumulator) && !file_we &&
        status_flags == $past(status_flags))
        else $error("nop changed state");
    flush_hold_a: assert property (phase == PH_Q4 && flush_cycle |=>
        prog_addr == $past(prog_addr) && !file_we)
        else $error("flush cycle executed");
endmodule

// >>> prog_mem_model.sv
`timescale 1ns/1ps
// program memory and register file as the core sees them
module prog_mem_model
    import core_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // program memory
    input wire logic [PC_W-1:0] prog_addr,
    output logic [15:0] instr_word,
    // register file
    input wire logic [ADDR_W-1:0] file_addr,
    input wire logic [DATA_W-1:0] file_wdata,
    input wire logic file_we,
    output logic [DATA_W-1:0] file_rdata
);
    logic [15:0] mem [0:255];
    logic [DATA_W-1:0] rf [0:4095];

    // word fetch; only 512 bytes are modelled, so higher addresses alias
    assign instr_word = mem[prog_addr[8:1]];
    assign file_rdata = rf[file_addr];

    // a write lands at the edge that closes the write pulse
    always @(posedge clk_sys) begin
        if (file_we) begin
            rf[file_addr] <= file_wdata;
        end
    end
endmodule

// >>> return_stack.sv
`timescale 1ns/1ps
// hardware return stack; the top entry is its own flip-flop
module return_stack #(
    parameter int DEPTH = 31,
    parameter int WIDTH = 21
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_value,
    // state
    output logic [WIDTH-1:0] top
);
    localparam int PTR_W = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_bad_depth
        $error("return_stack needs DEPTH of at least 2");
    end

    logic [WIDTH-1:0] below [DEPTH-1];
    logic [PTR_W-1:0] count;
    logic [WIDTH-1:0] next_top;
    logic [PTR_W-1:0] next_count;
    logic wr_en;
    logic [PTR_W-1:0] wr_idx;

    // push when full is dropped rather than wrapping, so old returns survive
    always_comb begin
        next_top = top;
        next_count = count;
        wr_en = 1'b0;
        wr_idx = count - PTR_W'(1);
        if (clear) begin
            next_top = '0;
            next_count = '0;
        end else if (push && count != PTR_W'(DEPTH)) begin
            wr_en = count != '0;
            next_top = push_value;
            next_count = count + PTR_W'(1);
        end else if (pop) begin
            // an empty stack pops as zero
            next_top = (count > PTR_W'(1)) ? below[count - PTR_W'(2)] : '0;
            next_count = (count != '0) ? count - PTR_W'(1) : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            top <= '0;
            count <= '0;
            for (int i = 0; i < DEPTH - 1; i++) begin
                below[i] <= '0;
            end
        end else begin
            top <= next_top;
            count <= next_count;
            if (wr_en) begin
                below[wr_idx] <= top;
            end
        end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
// one program runs throughout; each task appends its own code
module testbench
    import core_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic pclat_load = 1'b0;
    logic [7:0] pclat_high_value = 8'h5a;
    logic [4:0] pclat_upper_value = 5'h13;
    logic [DATA_W-1:0] accumulator_shadow = 8'hc4;
    logic [FLAGS_W-1:0] flags_shadow = 5'h15;
    logic [BANK_W-1:0] bank_select_shadow = 4'h3;
    logic [15:0] instr_word;
    logic [PC_W-1:0] prog_addr, return_stack_top;
    logic [DATA_W-1:0] file_rdata, file_wdata, accumulator;
    logic [DATA_W-1:0] product_high_byte, product_low_byte;
    logic [ADDR_W-1:0] file_addr;
    logic [FLAGS_W-1:0] status_flags;
    logic [BANK_W-1:0] bank_select_register;
    logic [7:0] pc_latch_high;
    logic [4:0] pc_latch_upper;
    logic file_we, flush_cycle;
    logic high_priority_global_enable, low_priority_global_enable;
    int bad_count = 0;
    int checks = 0;
    int wp = 0;

    mul_neg_stack_return_ops dut_u (
        .clk_sys, .arst_n, .instr_word, .prog_addr, .file_rdata,
        .file_addr, .file_wdata, .file_we, .accumulator_shadow,
        .flags_shadow, .bank_select_shadow, .pclat_load,
        .pclat_high_value, .pclat_upper_value, .accumulator,
        .status_flags, .bank_select_register, .product_high_byte,
        .product_low_byte, .return_stack_top,
        .high_priority_global_enable, .low_priority_global_enable,
        .pc_latch_high, .pc_latch_upper, .flush_cycle
    );

    prog_mem_model pm_u (
        .clk_sys, .prog_addr, .instr_word, .file_addr, .file_wdata,
        .file_we, .file_rdata
    );

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input string n, input logic [20:0] s, e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic pc_is(input int e);
        chk("pc", prog_addr, 21'(e));
    endtask

    // whole instruction cycles; sampling 1 ns after the edge lets it settle
    task automatic step(input int n);
        repeat (4 * n) @(posedge clk_sys);
        #1;
    endtask

    task automatic put(input logic [15:0] w);
        pm_u.mem[wp] = w;
        wp++;
    endtask

    task automatic stop_test;
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // forward call, backward call, then both interrupt returns
    task automatic t_call_iret;
        pclat_load = 1'b1;
        put(16'hd878);
        pm_u.mem[121] = 16'hdfeb;
        pm_u.mem[101] = 16'h0011;
        pm_u.mem[122] = 16'h0010;
        step(1);
        pclat_load = 1'b0;
        pc_is(242);
        chk("stack_top", return_stack_top, 21'd2);
        chk("flush", 21'(flush_cycle), 21'd1);
        step(1);
        pc_is(242);
        chk("flush", 21'(flush_cycle), 21'd0);
        step(1);
        pc_is(202);
        chk("stack_top", return_stack_top, 21'd244);
        step(2);
        pc_is(244);
        chk("stack_top", return_stack_top, 21'd2);
        chk("hi_en", 21'(high_priority_global_enable), 21'd1);
        chk("lo_en", 21'(low_priority_global_enable), 21'd0);
        chk("acc", 21'(accumulator), 21'hc4);
        chk("flags", 21'(status_flags), 21'h15);
        chk("bank", 21'(bank_select_register), 21'h3);
        chk("lat_hi", 21'(pc_latch_high), 21'h5a);
        chk("lat_up", 21'(pc_latch_upper), 21'h13);
        // new shadow values must be ignored by the plain return
        accumulator_shadow = 8'h3c;
        flags_shadow = 5'h0a;
        bank_select_shadow = 4'h9;
        step(2);
        pc_is(2);
        chk("lo_en", 21'(low_priority_global_enable), 21'd1);
        chk("acc", 21'(accumulator), 21'hc4);
        chk("flags", 21'(status_flags), 21'h15);
        chk("lat_hi", 21'(pc_latch_high), 21'h5a);
        // the plain return also discards one fetch before code resumes
        step(1);
        pc_is(2);
        chk("flush", 21'(flush_cycle), 21'd0);
        wp = 1;
    endtask

    // decoy at 0x090 catches a high access offset kept in bank 0
    task automatic t_mul;
        logic [15:0] op [5] = '{16'h0de2, 16'h0205, 16'h0305, 16'h0290,
            16'h0390};
        logic [15:0] pr [5] = '{16'had08, 16'h8a94, 16'h0188, 16'h00c4,
            16'h0000};
        int p;
        p = 2 * wp;
        pm_u.rf[12'h005] = 8'hb5;
        pm_u.rf[12'h305] = 8'h02;
        pm_u.rf[12'hf90] = 8'h01;
        pm_u.rf[12'h090] = 8'h55;
        foreach (op[i]) begin
            put(op[i]);
        end
        foreach (op[i]) begin
            step(1);
            pc_is(p + 2 * i + 2);
            chk("prod", 21'({product_high_byte, product_low_byte}),
                21'(pr[i]));
            chk("acc", 21'(accumulator), 21'hc4);
            chk("flags", 21'(status_flags), 21'h15);
        end
        chk("file", 21'(pm_u.rf[12'h005]), 21'hb5);
    endtask

    // zero, 0x80 and both bank forms of the negate
    task automatic t_negate;
        logic [11:0] fa [4] = '{12'h006, 12'h007, 12'h380, 12'hf81};
        logic [7:0] fv [4] = '{8'h3a, 8'h00, 8'h80, 8'h01};
        logic [7:0] nv [4] = '{8'hc6, 8'h00, 8'h80, 8'hff};
        logic [4:0] fl [4] = '{5'h10, 5'h07, 5'h1a, 5'h10};
        pm_u.rf[12'h080] = 8'h11;
        pm_u.rf[12'h081] = 8'h22;
        foreach (fa[i]) begin
            pm_u.rf[fa[i]] = fv[i];
        end
        put(16'h6c06);
        put(16'h6c07);
        put(16'h6d80);
        put(16'h6c81);
        put(16'h0000);
        foreach (fa[i]) begin
            step(1);
            chk("we", 21'(file_we), 21'd1);
            chk("wdata", 21'(file_wdata), 21'(nv[i]));
            chk("flags", 21'(status_flags), 21'(fl[i]));
        end
        step(1);
        chk("we", 21'(file_we), 21'd0);
        foreach (fa[i]) begin
            chk("file", 21'(pm_u.rf[fa[i]]), 21'(nv[i]));
        end
        chk("decoy", 21'(pm_u.rf[12'h080]), 21'h11);
        chk("decoy", 21'(pm_u.rf[12'h081]), 21'h22);
    endtask

    task automatic t_nop;
        int p;
        p = 2 * wp;
        put(16'hf123);
        put(16'h0000);
        put(16'hffff);
        for (int i = 1; i <= 3; i++) begin
            step(1);
            pc_is(p + 2 * i);
            chk("acc", 21'(accumulator), 21'hc4);
            chk("flags", 21'(status_flags), 21'h10);
            chk("prod", 21'({product_high_byte, product_low_byte}),
                21'h0);
            chk("we", 21'(file_we), 21'd0);
        end
    endtask

    task automatic t_stack;
        int p;
        int n;
        p = 2 * wp;
        n = (300 - p - 10) / 2;
        put(16'h0005);
        put(16'h0005);
        put(16'h0006);
        put(16'h0006);
        put(16'hd800 | {5'h00, n[10:0]});
        pm_u.mem[150] = 16'h0c77;
        step(1);
        chk("stack_top", return_stack_top, 21'(p + 2));
        step(1);
        chk("stack_top", return_stack_top, 21'(p + 4));
        step(1);
        chk("stack_top", return_stack_top, 21'(p + 2));
        pc_is(p + 6);
        step(1);
        pc_is(p + 8);
        step(1);
        pc_is(300);
        chk("stack_top", return_stack_top, 21'(p + 10));
        step(2);
        pc_is(p + 10);
        chk("acc", 21'(accumulator), 21'h77);
        chk("flags", 21'(status_flags), 21'h10);
        chk("flush", 21'(flush_cycle), 21'd1);
        chk("lat_hi", 21'(pc_latch_high), 21'h5a);
        chk("lat_up", 21'(pc_latch_upper), 21'h13);
        step(1);
        pc_is(p + 10);
    endtask

    // everything is made non-zero first so the clear is visible
    task automatic t_swreset;
        put(16'h0d02);
        put(16'h0005);
        put(16'h00ff);
        step(2);
        chk("prod", 21'({product_high_byte, product_low_byte}),
            21'h00ee);
        step(1);
        pc_is(0);
        chk("acc", 21'(accumulator), 21'h0);
        chk("flags", 21'(status_flags), 21'h0);
        chk("bank", 21'(bank_select_register), 21'h0);
        chk("prod", 21'({product_high_byte, product_low_byte}),
            21'h0);
        chk("stack_top", return_stack_top, 21'h0);
        chk("hi_en", 21'(high_priority_global_enable), 21'd0);
        chk("lo_en", 21'(low_priority_global_enable), 21'd0);
        chk("lat_hi", 21'(pc_latch_high), 21'h0);
        chk("lat_up", 21'(pc_latch_upper), 21'h0);
    endtask

    // main sequence
    initial begin
        for (int i = 0; i < 256; i++) begin
            pm_u.mem[i] = 16'h0000;
        end
        for (int i = 0; i < 4096; i++) begin
            pm_u.rf[i] = 8'h00;
        end
        repeat (20) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        t_call_iret;
        t_mul;
        t_negate;
        t_nop;
        t_stack;
        t_swreset;
        stop_test;
    end

    // the tests need about 150 cycles; this cuts a hang short
    initial begin
        repeat (1000) @(posedge clk_sys);
        bad_count++;
        stop_test;
    end
endmodule
